/* File: common/rhs_pkg.sv */
package rhs_pkg;

    // command codes: read code, write code = read code | 0x80
    localparam logic [7:0] CMD_HUB_STATUS_RD   = 8'h14;
    localparam logic [7:0] CMD_HUB_STATUS_WR   = 8'h94;
    localparam logic [7:0] CMD_PORT1_STATUS_RD = 8'h15;
    localparam logic [7:0] CMD_PORT1_STATUS_WR = 8'h95;
    localparam logic [7:0] CMD_PORT2_STATUS_RD = 8'h16;
    localparam logic [7:0] CMD_PORT2_STATUS_WR = 8'h96;
    localparam logic [7:0] CMD_WRITE_BIT_MASK  = 8'h80;

    // hub status bit positions
    localparam int BIT_CLEAR_WAKE    = 31;
    localparam int BIT_OC_CHANGE     = 17;
    localparam int BIT_SET_GLOBAL    = 16;
    localparam int BIT_WAKE_ENABLE   = 15;
    localparam int BIT_OC_INDICATOR  = 1;
    localparam int BIT_CLEAR_GLOBAL  = 0;

    // port status bit positions
    localparam int PBIT_CONNECT        = 0;
    localparam int PBIT_POWER          = 8;
    localparam int PBIT_CONNECT_CHANGE = 16;
    localparam int PORT_HALF_WIDTH     = 16;

    localparam int           DEFAULT_PORT_COUNT = 2;
    localparam logic [31:0]  RESET_WORD         = 32'h0000_0000;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [31:0] wdata;
    } rhs_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } rhs_rsp_t;

endpackage : rhs_pkg

/* File: hdl/rhs_hub_status.sv */
`timescale 1ns/1ps
module rhs_hub_status #(
    parameter int PORT_COUNT = rhs_pkg::DEFAULT_PORT_COUNT
) (
    input  wire logic                 clk_in,
    input  wire logic                 srst_in,
    input  wire rhs_pkg::rhs_cmd_t    cmd_in,
    input  wire logic                 power_switch_select_in,
    input  wire logic                 per_port_overcurrent_in,
    input  wire logic [PORT_COUNT:0]  port_power_mask_in,
    input  wire logic                 overcurrent_pin_in,
    input  wire logic [PORT_COUNT:1]  connect_pin_in,
    input  wire logic                 suspend_state_in,
    output rhs_pkg::rhs_rsp_t         rsp_out,
    output logic [PORT_COUNT:1]       port_power_state_out,
    output logic                      resume_state_out,
    output logic                      resume_seen_interrupt_out
);
    // pins cross into the clock domain through two flops
    logic                oc_meta;
    logic                oc_sync;
    logic [PORT_COUNT:1] conn_meta;
    logic [PORT_COUNT:1] conn_sync;

    logic wake_enable;
    logic next_wake_enable;
    logic oc_ind;
    logic next_oc_ind;
    logic oc_change;
    logic next_oc_change;
    logic resume_q;
    logic next_resume_q;
    logic resume_irq;
    logic next_resume_irq;
    rhs_pkg::rhs_rsp_t   rsp;
    rhs_pkg::rhs_rsp_t   next_rsp;
    logic [PORT_COUNT:1] pwr_q;

    logic                hub_wr;
    logic                hub_rd;
    logic [PORT_COUNT:1] port_wr;
    logic [PORT_COUNT:1] port_rd;
    logic [PORT_COUNT:1] pwr_set;
    logic [PORT_COUNT:1] pwr_clr;
    logic [PORT_COUNT:1] conn_change;
    logic [31:0]         port_word [PORT_COUNT:1];
    logic [31:0]         hub_word;
    logic                oc_eff;

    function automatic logic code_hit(input rhs_pkg::rhs_cmd_t c, input logic [7:0] rd_code,
                                      input logic wr);
        code_hit = c.valid && (c.write == wr) &&
                   (c.code == (wr ? (rd_code | rhs_pkg::CMD_WRITE_BIT_MASK) : rd_code));
    endfunction : code_hit

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            oc_meta   <= 1'b0;
            oc_sync   <= 1'b0;
            conn_meta <= '0;
            conn_sync <= '0;
        end else begin
            oc_meta   <= overcurrent_pin_in;
            oc_sync   <= oc_meta;
            conn_meta <= connect_pin_in;
            conn_sync <= conn_meta;
        end
    end

    always_comb begin
        hub_wr = code_hit(cmd_in, rhs_pkg::CMD_HUB_STATUS_RD, 1'b1);
        hub_rd = code_hit(cmd_in, rhs_pkg::CMD_HUB_STATUS_RD, 1'b0);
    end

    // one register per downstream port; codes run up from 15h
    genvar gi;
    generate
        for (gi = 1; gi <= PORT_COUNT; gi++) begin : g_port
            localparam logic [7:0] RD_CODE = rhs_pkg::CMD_PORT1_STATUS_RD + 8'(gi - 1);
            always_comb begin
                port_wr[gi] = code_hit(cmd_in, RD_CODE, 1'b1);
                port_rd[gi] = code_hit(cmd_in, RD_CODE, 1'b0);
                // with power_switch_select_in high, a set mask bit keeps the port off the global commands
                pwr_set[gi] = hub_wr && cmd_in.wdata[rhs_pkg::BIT_SET_GLOBAL] &&
                    (!power_switch_select_in || !port_power_mask_in[gi]);
                pwr_clr[gi] = hub_wr && cmd_in.wdata[rhs_pkg::BIT_CLEAR_GLOBAL] &&
                    (!power_switch_select_in || !port_power_mask_in[gi]);
            end
            rhs_port_reg u_port (
                .clk_in             (clk_in),
                .srst_in            (srst_in),
                .connect_in         (conn_sync[gi]),
                .power_set_in       (pwr_set[gi]),
                .power_clr_in       (pwr_clr[gi]),
                .wr_in              (port_wr[gi]),
                .wdata_in           (cmd_in.wdata),
                .status_out         (port_word[gi]),
                .connect_change_out (conn_change[gi])
            );
            always_comb begin
                pwr_q[gi] = port_word[gi][rhs_pkg::PBIT_POWER];
            end
        end
    endgenerate

    always_comb begin
        oc_eff         = per_port_overcurrent_in ? 1'b0 : oc_sync;
        next_oc_ind    = oc_eff;
        next_oc_change = oc_change;
        if (hub_wr && cmd_in.wdata[rhs_pkg::BIT_OC_CHANGE]) begin
            next_oc_change = 1'b0;
        end
        if (oc_eff != oc_ind) begin
            next_oc_change = 1'b1;
        end
        next_wake_enable = wake_enable;
        if (hub_wr && cmd_in.wdata[rhs_pkg::BIT_WAKE_ENABLE]) begin
            next_wake_enable = 1'b1;
        end
        if (hub_wr && cmd_in.wdata[rhs_pkg::BIT_CLEAR_WAKE]) begin
            next_wake_enable = 1'b0;
        end
        // resume is held until suspend is released by the host state logic
        next_resume_q   = resume_q && suspend_state_in;
        next_resume_irq = 1'b0;
        if (wake_enable && suspend_state_in && !resume_q && (|conn_change)) begin
            next_resume_q   = 1'b1;
            next_resume_irq = 1'b1;
        end
    end

    always_comb begin
        hub_word = rhs_pkg::RESET_WORD;
        hub_word[rhs_pkg::BIT_OC_CHANGE]    = oc_change;
        hub_word[rhs_pkg::BIT_WAKE_ENABLE]  = wake_enable;
        hub_word[rhs_pkg::BIT_OC_INDICATOR] = oc_ind;
        hub_word[rhs_pkg::BIT_SET_GLOBAL]   = 1'b0;
        hub_word[rhs_pkg::BIT_CLEAR_GLOBAL] = 1'b0;
        next_rsp.valid = hub_rd;
        next_rsp.rdata = hub_rd ? hub_word : rhs_pkg::RESET_WORD;
        for (int i = 1; i <= PORT_COUNT; i++) begin
            if (port_rd[i]) begin
                next_rsp.valid = 1'b1;
                next_rsp.rdata = port_word[i];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wake_enable <= 1'b0;
            oc_ind      <= 1'b0;
            oc_change   <= 1'b0;
            resume_q    <= 1'b0;
            resume_irq  <= 1'b0;
            rsp         <= '0;
            port_power_state_out <= '0;
        end else begin
            wake_enable <= next_wake_enable;
            oc_ind      <= next_oc_ind;
            oc_change   <= next_oc_change;
            resume_q    <= next_resume_q;
            resume_irq  <= next_resume_irq;
            rsp         <= next_rsp;
            port_power_state_out <= pwr_q;
        end
    end

    always_comb begin
        rsp_out                   = rsp;
        resume_state_out          = resume_q;
        resume_seen_interrupt_out = resume_irq;
    end
endmodule : rhs_hub_status

/* File: hdl/rhs_port_reg.sv */
`timescale 1ns/1ps
// one downstream port: status in the low half, a sticky connect change flag in the high half
module rhs_port_reg (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        connect_in,
    input  wire logic        power_set_in,
    input  wire logic        power_clr_in,
    input  wire logic        wr_in,
    input  wire logic [31:0] wdata_in,
    output logic [31:0]      status_out,
    output logic             connect_change_out
);
    logic connect_q;
    logic next_connect_q;
    logic power;
    logic next_power;
    logic change;
    logic next_change;
    logic set_ev;

    always_comb begin
        set_ev         = (connect_in != connect_q);
        next_connect_q = connect_in;
        next_power     = power;
        if (power_set_in) begin
            next_power = 1'b1;
        end else if (power_clr_in) begin
            next_power = 1'b0;
        end
        next_change = change;
        if (wr_in && wdata_in[rhs_pkg::PBIT_CONNECT_CHANGE]) begin
            next_change = 1'b0;
        end
        if (set_ev) begin
            next_change = 1'b1; // set beats write-one clear
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            connect_q <= 1'b0;
            power     <= 1'b0;
            change    <= 1'b0;
        end else begin
            connect_q <= next_connect_q;
            power     <= next_power;
            change    <= next_change;
        end
    end

    always_comb begin
        status_out = rhs_pkg::RESET_WORD;
        status_out[rhs_pkg::PBIT_CONNECT]        = connect_q;
        status_out[rhs_pkg::PBIT_POWER]          = power;
        status_out[rhs_pkg::PBIT_CONNECT_CHANGE] = change;
        connect_change_out = set_ev;
    end
endmodule : rhs_port_reg

/* File: verification/rhs_hub_status_assertions.sv */
`timescale 1ns/1ps
module rhs_hub_status_assertions #(
    parameter int PORT_COUNT = 2
) (
    input wire logic                clk_in,
    input wire logic                srst_in,
    input wire rhs_pkg::rhs_cmd_t   cmd_in,
    input wire logic                power_switch_select_in,
    input wire logic                per_port_overcurrent_in,
    input wire logic [PORT_COUNT:0] port_power_mask_in,
    input wire logic                overcurrent_pin_in,
    input wire logic [PORT_COUNT:1] connect_pin_in,
    input wire logic                suspend_state_in,
    input wire rhs_pkg::rhs_rsp_t   rsp_out,
    input wire logic [PORT_COUNT:1] port_power_state_out,
    input wire logic                resume_state_out,
    input wire logic                resume_seen_interrupt_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_hub_wr(int b);
        cmd_in.valid && cmd_in.write && cmd_in.code == rhs_pkg::CMD_HUB_STATUS_WR && cmd_in.wdata[b];
    endsequence
    sequence s_rd(logic [7:0] c);
        cmd_in.valid && !cmd_in.write && cmd_in.code == c;
    endsequence
    property p_hub_rd;
        s_rd(rhs_pkg::CMD_HUB_STATUS_RD) |=> rsp_out.valid && !rsp_out.rdata[16] && !rsp_out.rdata[0];
    endproperty
    a_hub_rd: assert property (p_hub_rd) else $error("hub read answer wrong");
    property p_port_rd;
        s_rd(rhs_pkg::CMD_PORT2_STATUS_RD) |=> rsp_out.valid;
    endproperty
    a_port_rd: assert property (p_port_rd) else $error("port read not answered");
    property p_oc_per_port;
        s_rd(rhs_pkg::CMD_HUB_STATUS_RD) ##0 per_port_overcurrent_in |=> !rsp_out.rdata[1];
    endproperty
    a_oc_per_port: assert property (p_oc_per_port) else $error("hub oc bit not zero");
    property p_global_on;
        s_hub_wr(16) ##0 !power_switch_select_in |-> ##2 &port_power_state_out;
    endproperty
    a_global_on: assert property (p_global_on) else $error("global power on failed");
    property p_global_off;
        s_hub_wr(0) ##0 !cmd_in.wdata[16] && !power_switch_select_in |-> ##2 !(|port_power_state_out);
    endproperty
    a_global_off: assert property (p_global_off) else $error("global power off failed");
    property p_port_on;
        s_hub_wr(16) ##0 power_switch_select_in
            |-> ##2 &(port_power_state_out | port_power_mask_in[PORT_COUNT:1]);
    endproperty
    a_port_on: assert property (p_port_on) else $error("unmasked port not powered");
    property p_port_off;
        s_hub_wr(0) ##0 !cmd_in.wdata[16] && power_switch_select_in
            |-> ##2 !(|(port_power_state_out & ~port_power_mask_in[PORT_COUNT:1]));
    endproperty
    a_port_off: assert property (p_port_off) else $error("unmasked port still on");
    property p_resume;
        resume_seen_interrupt_out |=> !resume_seen_interrupt_out && resume_state_out;
    endproperty
    a_resume: assert property (p_resume) else $error("resume pulse or state wrong");
endmodule : rhs_hub_status_assertions
bind rhs_hub_status rhs_hub_status_assertions #(.PORT_COUNT(PORT_COUNT)) rhs_hub_status_assertions_i (
    .clk_in(clk_in), .srst_in(srst_in), .cmd_in(cmd_in),
    .power_switch_select_in(power_switch_select_in), .per_port_overcurrent_in(per_port_overcurrent_in),
    .port_power_mask_in(port_power_mask_in), .overcurrent_pin_in(overcurrent_pin_in),
    .connect_pin_in(connect_pin_in), .suspend_state_in(suspend_state_in), .rsp_out(rsp_out),
    .port_power_state_out(port_power_state_out), .resume_state_out(resume_state_out),
    .resume_seen_interrupt_out(resume_seen_interrupt_out));

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module tb_top;
    logic              clk_in, srst_in, pwr_sel, oc_per_port, oc_pin, suspend;
    rhs_pkg::rhs_cmd_t cmd_in;
    rhs_pkg::rhs_rsp_t rsp_out;
    logic [2:0]        mask;
    logic [2:1]        conn, pwr;
    logic              res_state, res_irq;
    int                failures, samples_checked, cycles, n;
    logic [2:0]        pm [5] = '{3'h4, 3'h0, 3'h0, 3'h2, 3'h0};
    logic [31:0]       pd [5] = '{32'h0001_0000, 32'h0, 32'h0001_0000, 32'h1, 32'h1};
    logic [2:1]        pe [5] = '{2'h1, 2'h1, 2'h3, 2'h1, 2'h0};
    rhs_hub_status #(.PORT_COUNT(2)) rhs_hub_status_i (.clk_in(clk_in), .srst_in(srst_in),
        .cmd_in(cmd_in), .power_switch_select_in(pwr_sel), .per_port_overcurrent_in(oc_per_port),
        .port_power_mask_in(mask), .overcurrent_pin_in(oc_pin), .connect_pin_in(conn),
        .suspend_state_in(suspend), .rsp_out(rsp_out), .port_power_state_out(pwr),
        .resume_state_out(res_state), .resume_seen_interrupt_out(res_irq));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // nothing here needs more than a few hundred cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end
    task end_of_test;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task wt(input int k);
        repeat (k) @(posedge clk_in);
    endtask : wt
    task put(input logic [7:0] c, input logic w, input logic [31:0] d);
        @(posedge clk_in);
        cmd_in <= '{1'b1, w, c, d};
        @(posedge clk_in);
        cmd_in <= '0;
        #1;
    endtask : put
    task rd(input logic [7:0] c, input logic [31:0] m, input logic [31:0] e);
        put(c, 1'b0, 32'h0);
        `CHK("valid", 1'b1, rsp_out.valid)
        `CHK("rdata", e, rsp_out.rdata & m)
    endtask : rd
    initial begin
        // ten bits in all: reset high, every other input low
        {srst_in, pwr_sel, oc_per_port, oc_pin, suspend, mask, conn} = 10'h200;
        cmd_in = '0;
        wt(2);
        srst_in <= 1'b0;
        rd(8'h14, 32'hFFFF_FFFF, 32'h0);
        put(8'h17, 1'b0, 32'h0);
        `CHK("refused", 1'b0, rsp_out.valid)
        put(8'h94, 1'b1, 32'h0001_0000);
        wt(2);
        `CHK("pwr", 2'h3, pwr)
        rd(8'h14, 32'h0001_0001, 32'h0);
        rd(8'h15, 32'h0000_0100, 32'h0000_0100);
        rd(8'h16, 32'h0000_0100, 32'h0000_0100);
        put(8'h94, 1'b1, 32'h1);
        wt(2);
        `CHK("pwr", 2'h0, pwr)
        pwr_sel <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            mask <= pm[i];
            put(8'h94, 1'b1, pd[i]);
            wt(2);
            `CHK("pwr", pe[i], pwr)
        end
        pwr_sel <= 1'b0;
        oc_pin <= 1'b1;
        wt(4);
        rd(8'h14, 32'h0002_0002, 32'h0002_0002);
        put(8'h94, 1'b1, 32'h0);
        rd(8'h14, 32'h0002_0000, 32'h0002_0000);
        put(8'h94, 1'b1, 32'h0002_0000);
        rd(8'h14, 32'h0002_0002, 32'h0000_0002);
        oc_pin <= 1'b0;
        wt(4);
        rd(8'h14, 32'h0002_0002, 32'h0002_0000);
        oc_per_port <= 1'b1;
        oc_pin <= 1'b1;
        wt(4);
        rd(8'h14, 32'h0000_0002, 32'h0);
        put(8'h94, 1'b1, 32'h0000_8000);
        put(8'h94, 1'b1, 32'h0);
        rd(8'h14, 32'h0000_8000, 32'h0000_8000);
        suspend <= 1'b1;
        conn <= 2'h1;
        n = 0;
        while (res_irq !== 1'b1 && n < 20) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        `CHK("resume_irq", 1'b1, res_irq)
        `CHK("resume_state", 1'b1, res_state)
        rd(8'h15, 32'h0001_0001, 32'h0001_0001);
        rd(8'h16, 32'h0001_0001, 32'h0);
        put(8'h94, 1'b1, 32'h8000_0000);
        rd(8'h14, 32'h0000_8000, 32'h0);
        end_of_test();
    end
endmodule : tb_top
